// ===== hw/supply_regs_pkg.sv
// constants and types shared by the display supply register bank
package supply_regs_pkg;

  // register offsets and the number of stored settings
  localparam logic [7:0] OFS_IDENT = 8'h00;
  localparam logic [7:0] OFS_TEMP = 8'h01;
  localparam logic [7:0] OFS_CTRL = 8'h02;
  localparam logic [7:0] OFS_MASK = 8'h03;
  localparam logic [7:0] OFS_NV_FIRST = 8'h21;
  localparam logic [7:0] OFS_NV_LAST = 8'h25;
  localparam logic [7:0] OFS_SET_POS = 8'h23;
  localparam logic [7:0] OFS_SET_GON = 8'h24;
  localparam logic [7:0] OFS_SET_GOFF = 8'h25;
  localparam logic [7:0] OFS_PROGRAM = 8'h78;
  localparam logic [7:0] OFS_RELOAD = 8'h79;
  localparam logic [7:0] OFS_RESTART = 8'h7a;
  localparam int NV_DEPTH = 5;

  // control register fields
  localparam int CTRL_PAR_EN_BIT = 7;
  localparam int CTRL_START_BIT = 6;

  // mask register fields, one bit per rail
  localparam int MASK_POS_BIT = 6;
  localparam int MASK_NEG_BIT = 4;
  localparam int MASK_GON_BIT = 2;
  localparam int MASK_GOFF_BIT = 0;
  localparam logic [7:0] MASK_WRITABLE = 8'h55;

  // order of the undervoltage inputs
  localparam int UV_GOFF = 0;
  localparam int UV_GON = 1;
  localparam int UV_NEG = 2;
  localparam int UV_POS = 3;

  // readable width of the narrow stored settings
  localparam logic [7:0] NV_SIX_BITS = 8'h3f;
  localparam logic [7:0] NV_SEVEN_BITS = 8'h7f;

  // values after reset, and the write tally cap
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TEMP_RST = 8'h00;
  localparam logic [7:0] NV_RST = 8'h00;
  localparam logic PAR_EN_RST = 1'b0;
  localparam logic [2:0] TALLY_RST = 3'h0;
  localparam logic [2:0] TALLY_MAX = 3'h6;

  // serial framing counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_REG, ST_WDATA, ST_RDATA} link_state_t;

endpackage

// ===== hw/level_sync.sv
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule

// ===== hw/supply_regs.sv
// serial-bus register bank of a display power supply
`timescale 1ns/1ps

// Contract
// (R01) Writing 1 to control bit 6 starts the selected power-on sequence.
// (R02) The start bit resets to 0, or to 1 on stand-alone builds, which then start on their own.
// (R03) Control bits 5:3 show the non-volatile write tally, which never passes 6.
// (R04) Control bits 2:0 return a fixed read-only revision code.
// (R05) Offset zero returns a fixed six-bit part code in bits 5:0 and zeros above.
// (R06) The temperature register holds the eight-bit reference pin reading and reads 0 after reset.
// (R07) The mask register gates each rail undervoltage off the fault pin, bits 6, 4, 2, 0, reset 0.
// (R08) An unmasked gate-on undervoltage pulls the fault pin low.
// (R09) An unmasked gate-off undervoltage pulls the fault pin low.
// (R10) Writes to 0x78, 0x79 and 0x7A trigger program, reload and restart instead of storing.
// (R11) With parity enabled, writes need even parity over address, register and payload bytes.
// (R12) A parity error sets the error flag, answers NACK and writes nothing.
// (R13) With parity enabled the host writes one register per transaction.
// (R14) For commands with parity the host adjusts the payload byte, never the command byte.
module supply_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h29,
  parameter logic STANDALONE = 1'b0,
  parameter logic [5:0] PART_CODE = 6'h15,  // arbitrary value
  parameter logic [2:0] REV_CODE = 3'h3     // arbitrary value
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [7:0] temp_sample,
  input wire logic temp_valid,
  input wire logic [3:0] uv_raw,
  output logic fault_out_n,
  output logic seq_start_pulse,
  output logic program_pulse,
  output logic reload_pulse,
  output logic restart_pulse,
  output logic parity_error_flag
);

  logic scl_s;
  logic sda_s;
  logic [3:0] uv_s;
  logic scl_d_r;
  logic sda_d_r;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  // bus pins and rail comparators arrive from outside the clock domain
  level_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_bus_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  level_sync #(.WIDTH(4), .RST_VAL(4'h0)) u_uv_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .async_in(uv_raw),
    .sync_out(uv_s)
  );

  // edge history of the synchronised bus lines
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  // bus engine state
  supply_regs_pkg::link_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shin_r, shin_nxt;
  logic [7:0] shout_r, shout_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic oe_r, oe_nxt;
  logic par_acc_r, par_acc_nxt;
  logic wr_go;
  logic par_bad;
  logic rd_load;
  logic [7:0] rd_value;

  // register state
  logic par_en_r, par_en_nxt;
  logic start_r, start_nxt;
  logic [2:0] tally_r, tally_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] temp_r, temp_nxt;
  logic [7:0] nv_r [supply_regs_pkg::NV_DEPTH];
  logic [7:0] nv_nxt [supply_regs_pkg::NV_DEPTH];
  logic par_err_r, par_err_nxt;
  logic boot_r;
  logic seq_r, seq_nxt;
  logic prog_r, prog_nxt;
  logic reload_r, reload_nxt;
  logic restart_r, restart_nxt;
  logic fault_n_r, fault_n_nxt;
  logic [3:0] mask_vec;

  // read data mux; reserved bits and command offsets read as zero
  always_comb begin
    rd_value = 8'h00;
    case (addr_r)
      // (R05) fixed part code
      supply_regs_pkg::OFS_IDENT: rd_value = {2'b00, PART_CODE};
      supply_regs_pkg::OFS_TEMP: rd_value = temp_r;
      // (R03) (R04) tally and revision in control
      supply_regs_pkg::OFS_CTRL: rd_value = {par_en_r, start_r, tally_r, REV_CODE};
      supply_regs_pkg::OFS_MASK: rd_value = mask_r;
      supply_regs_pkg::OFS_SET_POS: rd_value = nv_r[3'(addr_r - supply_regs_pkg::OFS_NV_FIRST)] & supply_regs_pkg::NV_SIX_BITS;
      supply_regs_pkg::OFS_SET_GON: rd_value = nv_r[3'(addr_r - supply_regs_pkg::OFS_NV_FIRST)] & supply_regs_pkg::NV_SEVEN_BITS;
      supply_regs_pkg::OFS_SET_GOFF: rd_value = nv_r[3'(addr_r - supply_regs_pkg::OFS_NV_FIRST)] & supply_regs_pkg::NV_SIX_BITS;
      default: begin
        if (addr_r >= supply_regs_pkg::OFS_NV_FIRST && addr_r <= supply_regs_pkg::OFS_NV_LAST) begin
          rd_value = nv_r[3'(addr_r - supply_regs_pkg::OFS_NV_FIRST)];
        end
      end
    endcase
  end

  // bus engine: sample on rising scl, change sda on falling scl
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shin_nxt = shin_r;
    shout_nxt = shout_r;
    addr_nxt = addr_r;
    oe_nxt = oe_r;
    par_acc_nxt = par_acc_r;
    wr_go = 1'b0;
    par_bad = 1'b0;
    rd_load = 1'b0;
    if (stop_det) begin
      state_nxt = supply_regs_pkg::ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = supply_regs_pkg::ST_DEV;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
      par_acc_nxt = 1'b0;
    end else if (state_r != supply_regs_pkg::ST_IDLE) begin
      if (scl_rise) begin
        if (cnt_r < supply_regs_pkg::BYTE_BITS) begin
          shin_nxt = {shin_r[6:0], sda_s};
          cnt_nxt = cnt_r + 4'h1;
        end else if (cnt_r == supply_regs_pkg::BYTE_BITS) begin
          cnt_nxt = supply_regs_pkg::ACK_SLOT;
          // host nack ends a read burst
          if (state_r == supply_regs_pkg::ST_RDATA && sda_s) begin
            state_nxt = supply_regs_pkg::ST_IDLE;
          end
        end
      end else if (scl_fall) begin
        if (cnt_r == supply_regs_pkg::BYTE_BITS) begin
          oe_nxt = 1'b0;
          case (state_r)
            supply_regs_pkg::ST_DEV: begin
              if (shin_r[7:1] == SLAVE_ADDR) begin
                oe_nxt = 1'b1;
                par_acc_nxt = ^shin_r;
                state_nxt = shin_r[0] ? supply_regs_pkg::ST_RDATA : supply_regs_pkg::ST_REG;
              end else begin
                state_nxt = supply_regs_pkg::ST_IDLE;
              end
            end
            supply_regs_pkg::ST_REG: begin
              oe_nxt = 1'b1;
              // (R11) top address bit is parity
              addr_nxt = par_en_r ? {1'b0, shin_r[6:0]} : shin_r;
              par_acc_nxt = par_acc_r ^ (^shin_r);
              state_nxt = supply_regs_pkg::ST_WDATA;
            end
            supply_regs_pkg::ST_WDATA: begin
              // (R11) (R12) odd parity refuses write
              if (par_en_r && (par_acc_r ^ (^shin_r))) begin
                par_bad = 1'b1;
                state_nxt = supply_regs_pkg::ST_IDLE;
              end else begin
                wr_go = 1'b1;
                oe_nxt = 1'b1;
                addr_nxt = addr_r + 8'h01;
              end
            end
            default: begin
            end
          endcase
        end else if (cnt_r == supply_regs_pkg::ACK_SLOT) begin
          cnt_nxt = 4'h0;
          oe_nxt = 1'b0;
          if (state_r == supply_regs_pkg::ST_RDATA) begin
            rd_load = 1'b1;
            shout_nxt = rd_value;
            addr_nxt = addr_r + 8'h01;
            oe_nxt = !rd_value[7];
          end
        end else if (state_r == supply_regs_pkg::ST_RDATA) begin
          oe_nxt = !shout_r[~cnt_r[2:0]];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= supply_regs_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      shin_r <= 8'h00;
      shout_r <= 8'h00;
      addr_r <= 8'h00;
      oe_r <= 1'b0;
      par_acc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shin_r <= shin_nxt;
      shout_r <= shout_nxt;
      addr_r <= addr_nxt;
      oe_r <= oe_nxt;
      par_acc_r <= par_acc_nxt;
    end
  end

  assign mask_vec = {mask_r[supply_regs_pkg::MASK_POS_BIT], mask_r[supply_regs_pkg::MASK_NEG_BIT],
                     mask_r[supply_regs_pkg::MASK_GON_BIT], mask_r[supply_regs_pkg::MASK_GOFF_BIT]};

  // register file and command side effects
  always_comb begin
    par_en_nxt = par_en_r;
    start_nxt = start_r;
    tally_nxt = tally_r;
    mask_nxt = mask_r;
    temp_nxt = temp_r;
    nv_nxt = nv_r;
    par_err_nxt = par_err_r;
    seq_nxt = 1'b0;
    prog_nxt = 1'b0;
    reload_nxt = 1'b0;
    restart_nxt = 1'b0;
    // (R07) (R08) (R09) unmasked undervoltage pulls fault low
    fault_n_nxt = !(|(uv_s & ~mask_vec));
    // (R02) stand-alone build starts itself
    if (!boot_r && start_r) begin
      seq_nxt = 1'b1;
    end
    // (R06) latch each reference pin reading
    if (temp_valid) begin
      temp_nxt = temp_sample;
    end
    // (R12) sticky parity error flag
    if (par_bad) begin
      par_err_nxt = 1'b1;
    end
    if (wr_go) begin
      case (addr_r)
        supply_regs_pkg::OFS_CTRL: begin
          par_en_nxt = shin_r[supply_regs_pkg::CTRL_PAR_EN_BIT];
          start_nxt = shin_r[supply_regs_pkg::CTRL_START_BIT];
          // (R01) writing start runs sequence
          seq_nxt = shin_r[supply_regs_pkg::CTRL_START_BIT];
        end
        supply_regs_pkg::OFS_MASK: mask_nxt = shin_r & supply_regs_pkg::MASK_WRITABLE;
        // (R10) (R03) program only below tally cap
        supply_regs_pkg::OFS_PROGRAM: begin
          if (tally_r < supply_regs_pkg::TALLY_MAX) begin
            tally_nxt = tally_r + 3'h1;
            prog_nxt = 1'b1;
          end
        end
        supply_regs_pkg::OFS_RELOAD: reload_nxt = 1'b1;
        // restart also drops a stale parity error; no parity error can coincide with a write
        supply_regs_pkg::OFS_RESTART: begin
          restart_nxt = 1'b1;
          par_err_nxt = 1'b0;
        end
        default: begin
          if (addr_r >= supply_regs_pkg::OFS_NV_FIRST && addr_r <= supply_regs_pkg::OFS_NV_LAST) begin
            nv_nxt[3'(addr_r - supply_regs_pkg::OFS_NV_FIRST)] = shin_r;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      par_en_r <= supply_regs_pkg::PAR_EN_RST;
      start_r <= STANDALONE;
      tally_r <= supply_regs_pkg::TALLY_RST;
      mask_r <= supply_regs_pkg::MASK_RST;
      temp_r <= supply_regs_pkg::TEMP_RST;
      for (int i = 0; i < supply_regs_pkg::NV_DEPTH; i++) begin
        nv_r[i] <= supply_regs_pkg::NV_RST;
      end
      par_err_r <= 1'b0;
      boot_r <= 1'b0;
      seq_r <= 1'b0;
      prog_r <= 1'b0;
      reload_r <= 1'b0;
      restart_r <= 1'b0;
      fault_n_r <= 1'b1;
    end else begin
      par_en_r <= par_en_nxt;
      start_r <= start_nxt;
      tally_r <= tally_nxt;
      mask_r <= mask_nxt;
      temp_r <= temp_nxt;
      nv_r <= nv_nxt;
      par_err_r <= par_err_nxt;
      boot_r <= 1'b1;
      seq_r <= seq_nxt;
      prog_r <= prog_nxt;
      reload_r <= reload_nxt;
      restart_r <= restart_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  // open-drain line: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign fault_out_n = fault_n_r;
  assign seq_start_pulse = seq_r;
  assign program_pulse = prog_r;
  assign reload_pulse = reload_r;
  assign restart_pulse = restart_r;
  assign parity_error_flag = par_err_r;

  // checks next to the logic they guard
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_start_runs_seq: assert property (wr_go && addr_r == supply_regs_pkg::OFS_CTRL && shin_r[6] |=> seq_r) // R01
    else $error("start write did not pulse sequence start");
  a_boot_start_seq: assert property ($rose(boot_r) |-> seq_r == STANDALONE) // R02
    else $error("start after reset does not follow build option");
  a_tally_cap_six: assert property (tally_r <= supply_regs_pkg::TALLY_MAX) // R03
    else $error("write tally above six");
  a_read_ident_code: assert property (rd_load && addr_r == supply_regs_pkg::OFS_IDENT |=> shout_r == {2'b00, PART_CODE}) // R05
    else $error("part code read wrong");
  a_read_rev_code: assert property (rd_load && addr_r == supply_regs_pkg::OFS_CTRL |=> shout_r[2:0] == REV_CODE) // R04
    else $error("revision code read wrong");
  a_temp_follows_pin: assert property (temp_valid |=> temp_r == $past(temp_sample)) // R06
    else $error("temperature reading not taken");
  a_mask_blocks_all: assert property (mask_r == supply_regs_pkg::MASK_WRITABLE |=> fault_out_n) // R07
    else $error("masked rail pulled fault low");
  a_gate_on_fault: assert property (uv_s[supply_regs_pkg::UV_GON] && !mask_r[2] |=> !fault_out_n) // R08
    else $error("gate-on undervoltage missed");
  a_gate_off_fault: assert property (uv_s[supply_regs_pkg::UV_GOFF] && !mask_r[0] |=> !fault_out_n) // R09
    else $error("gate-off undervoltage missed");
  a_program_counts: assert property (prog_r |-> tally_r == $past(tally_r) + 3'h1) // R10
    else $error("program pulse without tally step");
  a_parity_nack_flag: assert property (par_bad |=> par_err_r && !sda_oe) // R12
    else $error("parity error not flagged or acked");
  a_parity_no_write: assert property (par_bad |=> $stable(mask_r) && $stable(par_en_r) && !prog_r) // R12
    else $error("write performed despite parity error");

  c_parity_error: cover property (par_bad);
  c_program_cmd: cover property (prog_r);
  c_ident_read: cover property (rd_load && addr_r == supply_regs_pkg::OFS_IDENT);
  c_fault_low: cover property ($fell(fault_out_n));

endmodule

// ===== test/i2c_host_model.sv
// behavioural serial bus host that reaches the register bank
`timescale 1ns/1ps
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h29
) (
  input wire logic core_clk,
  input wire logic sda_line,
  output logic scl_pin,
  output logic sda_low
);
  // core cycles per bus phase; the bench raises it to act as a slow host
  int half = 6;

  // bus idles with clock high and data released
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic bus_start();
    sda_low <= 1'b0;
    hold(half);
    scl_pin <= 1'b1;
    hold(half);
    sda_low <= 1'b1;
    hold(half);
    scl_pin <= 1'b0;
    hold(half);
  endtask

  task automatic bus_stop();
    sda_low <= 1'b1;
    hold(half);
    scl_pin <= 1'b1;
    hold(half);
    sda_low <= 1'b0;
    hold(half);
  endtask

  // data only moves a cycle after the clock fell, never beside a clock edge
  task automatic bit_out(input logic b);
    sda_low <= ~b;
    hold(half);
    scl_pin <= 1'b1;
    hold(half);
    scl_pin <= 1'b0;
    hold(1);
  endtask

  task automatic bit_in(output logic b);
    sda_low <= 1'b0;
    hold(half);
    scl_pin <= 1'b1;
    hold(half - 2);
    b = sda_line;
    hold(2);
    scl_pin <= 1'b0;
    hold(1);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(b);
    ack = ~b;
  endtask

  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask

  // even parity, one register per write, commands keep their byte
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d, input logic par, output logic ack);
    logic [7:0] r;
    logic a0;
    logic a1;
    r = ofs;
    if (par && (^{ADDR, 1'b0, r, d})) begin
      if (ofs >= 8'h78)
        d[7] = ~d[7];
      else
        r[7] = ~r[7];
    end
    bus_start();
    send_byte({ADDR, 1'b0}, a0);
    send_byte(r, a1);
    send_byte(d, ack);
    bus_stop();
    ack = ack & a0 & a1;
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    bus_start();
    send_byte({ADDR, 1'b0}, a);
    send_byte(ofs, a);
    bus_start();
    send_byte({ADDR, 1'b1}, a);
    get_byte(d, 1'b1);
    bus_stop();
  endtask
endmodule

// ===== test/lcd_supply_control_registers_test.sv
// self-checking bench for the display supply register bank
`timescale 1ns/1ps
module lcd_supply_control_registers_test;
  localparam logic [5:0] PART = 6'h2a;  // arbitrary value
  localparam logic [2:0] REV = 3'h5;    // arbitrary value
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] temp_sample = 8'h00;
  logic temp_valid = 1'b0;
  logic [3:0] uv_raw = 4'h0;
  logic scl, sda_low, sda_out, sda_oe, sda_line, ack;
  logic fault_out_n, seq_start_pulse, program_pulse, reload_pulse, restart_pulse, parity_error_flag;
  logic [7:0] rd;
  int n_fail = 0;
  int comparisons = 0;
  int n_seq = 0, n_prog = 0, n_rel = 0, n_rst = 0;
  logic solo_seq;
  int n_solo = 0;

  always #10 core_clk = ~core_clk;

  // open-drain data line with pull-up
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

  // pulses last one cycle, so they are counted rather than polled
  always @(posedge core_clk) begin
    if (seq_start_pulse === 1'b1) n_seq++;
    if (program_pulse === 1'b1) n_prog++;
    if (reload_pulse === 1'b1) n_rel++;
    if (restart_pulse === 1'b1) n_rst++;
    if (solo_seq === 1'b1) n_solo++;
  end

  supply_regs #(.PART_CODE(PART), .REV_CODE(REV)) supply_regs_i (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .temp_sample(temp_sample), .temp_valid(temp_valid), .uv_raw(uv_raw),
    .fault_out_n(fault_out_n), .seq_start_pulse(seq_start_pulse), .program_pulse(program_pulse),
    .reload_pulse(reload_pulse), .restart_pulse(restart_pulse), .parity_error_flag(parity_error_flag));

  i2c_host_model i2c_host_model_i (.core_clk(core_clk), .sda_line(sda_line), .scl_pin(scl), .sda_low(sda_low));

  // stand-alone build on an idle bus must run its power-on sequence once by itself
  supply_regs #(.STANDALONE(1'b1)) supply_regs_solo_i (
    .core_clk(core_clk), .nrst(nrst), .scl_in(1'b1), .sda_in(1'b1), .sda_out(), .sda_oe(),
    .temp_sample(8'h00), .temp_valid(1'b0), .uv_raw(4'h0), .fault_out_n(), .seq_start_pulse(solo_seq),
    .program_pulse(), .reload_pulse(), .restart_pulse(), .parity_error_flag());

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic par);
    i2c_host_model_i.write_reg(ofs, d, par, ack);
    repeat (4) @(posedge core_clk);
  endtask

  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    i2c_host_model_i.read_reg(ofs, rd);
    chk(rd, exp);
  endtask

  // fault path runs through a synchroniser, so allow a short bounded wait
  task automatic wait_fault(input logic exp);
    for (int i = 0; i < 20 && fault_out_n !== exp; i++) @(posedge core_clk);
    chk({7'h00, fault_out_n}, {7'h00, exp});
    if (fault_out_n !== exp) test_done();
  endtask

  task automatic t_reset();
    chk({7'h00, fault_out_n}, 8'h01);
    chk(8'(n_seq), 8'h00);
    chk(8'(n_solo), 8'h01);
    rd_chk(supply_regs_pkg::OFS_IDENT, {2'b00, PART});
    rd_chk(supply_regs_pkg::OFS_TEMP, 8'h00);
    rd_chk(supply_regs_pkg::OFS_CTRL, {5'h00, REV});
    rd_chk(supply_regs_pkg::OFS_MASK, 8'h00);
    wr(supply_regs_pkg::OFS_IDENT, 8'hff, 1'b0);
    rd_chk(supply_regs_pkg::OFS_IDENT, {2'b00, PART});
    rd_chk(8'h40, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_start();
    wr(supply_regs_pkg::OFS_CTRL, 8'h00, 1'b0);
    chk(8'(n_seq), 8'h00);
    wr(supply_regs_pkg::OFS_CTRL, 8'h40, 1'b0);
    chk(8'(n_seq), 8'h01);
    rd_chk(supply_regs_pkg::OFS_CTRL, {5'h08, REV});
    wr(supply_regs_pkg::OFS_CTRL, 8'h3f, 1'b0);
    rd_chk(supply_regs_pkg::OFS_CTRL, {5'h00, REV});
    $display("t_start done");
  endtask

  // each rail is tried with only its own mask set, then with only the others set
  task automatic t_mask();
    logic [7:0] mbit [4] = '{8'h01, 8'h04, 8'h10, 8'h40};
    wr(supply_regs_pkg::OFS_MASK, 8'hff, 1'b0);
    rd_chk(supply_regs_pkg::OFS_MASK, 8'h55);
    for (int i = 0; i < 4; i++) begin
      wr(supply_regs_pkg::OFS_MASK, mbit[i], 1'b0);
      uv_raw <= 4'h1 << i;
      repeat (8) @(posedge core_clk);
      wait_fault(1'b1);
      wr(supply_regs_pkg::OFS_MASK, 8'h55 ^ mbit[i], 1'b0);
      wait_fault(1'b0);
      uv_raw <= 4'h0;
      wait_fault(1'b1);
    end
    wr(supply_regs_pkg::OFS_MASK, 8'h00, 1'b0);
    $display("t_mask done");
  endtask

  // slow host here; a sample without its valid strobe must not land
  task automatic t_temp();
    i2c_host_model_i.half = 9;
    temp_sample <= 8'ha5;
    temp_valid <= 1'b1;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    temp_sample <= 8'h3c;
    rd_chk(supply_regs_pkg::OFS_TEMP, 8'ha5);
    i2c_host_model_i.half = 6;
    $display("t_temp done");
  endtask

  task automatic t_cmd();
    wr(supply_regs_pkg::OFS_PROGRAM, 8'h01, 1'b0);
    chk(8'(n_prog), 8'h01);
    rd_chk(supply_regs_pkg::OFS_CTRL, {5'h01, REV});
    repeat (6) wr(supply_regs_pkg::OFS_PROGRAM, 8'h01, 1'b0);
    chk(8'(n_prog), 8'h06);
    rd_chk(supply_regs_pkg::OFS_CTRL, {5'h06, REV});
    wr(supply_regs_pkg::OFS_RELOAD, 8'h01, 1'b0);
    chk(8'(n_rel), 8'h01);
    $display("t_cmd done");
  endtask

  task automatic t_parity();
    wr(supply_regs_pkg::OFS_CTRL, 8'h80, 1'b0);
    wr(supply_regs_pkg::OFS_MASK, 8'h04, 1'b1);
    chk({7'h00, ack}, 8'h01);
    rd_chk(supply_regs_pkg::OFS_MASK, 8'h04);
    wr(supply_regs_pkg::OFS_MASK, 8'h05, 1'b0);
    chk({7'h00, ack}, 8'h00);
    chk({7'h00, parity_error_flag}, 8'h01);
    rd_chk(supply_regs_pkg::OFS_MASK, 8'h04);
    wr(supply_regs_pkg::OFS_RESTART, 8'h01, 1'b1);
    chk(8'(n_rst), 8'h01);
    chk({7'h00, parity_error_flag}, 8'h00);
    $display("t_parity done");
  endtask

  // guard against a hung bus
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_start();
    t_mask();
    t_temp();
    t_cmd();
    t_parity();
    test_done();
  end
endmodule
